// ---- src/tcr_consts.svh ----
`ifndef TCR_CONSTS_SVH
`define TCR_CONSTS_SVH
`define TCR_OFF_CTRL    8'h00
`define TCR_OFF_EVGEN   8'h04
`define TCR_OFF_STATUS  8'h08
`define TCR_OFF_SLAVE   8'h0C
`define TCR_OFF_COUNT   8'h10
`define TCR_OFF_PSC     8'h14
`define TCR_OFF_ARR     8'h18
`define TCR_OFF_REP     8'h1C
`define TCR_B_RUN       0
`define TCR_B_DIR       1
`define TCR_B_UPDATE_DISABLE      2
`define TCR_B_URS       3
`define TCR_F_CMS       5:4
`define TCR_B_ARPE      6
`define TCR_B_UG        0
`define TCR_B_UIF       0
`define TCR_B_TIF       1
`define TCR_F_SMS       2:0
`define TCR_F_TS        6:4
`define TCR_B_ECE       8
`define TCR_B_ETP       9
`define TCR_F_EXT_TRIGGER_PRESCALE      11:10
`define TCR_F_ETF       15:12
`define TCR_B_EPOL      16
`define TCR_B_TIE       17
`define TCR_SMS_OFF     3'h0
`define TCR_SMS_EXT1    3'h7
`define TCR_CMS_EDGE    2'h0
`define TCR_ARR_RST     16'hFFFF
`define TCR_ZERO16      16'h0000
`define TCR_ONE16       16'h0001
`define TCR_ZERO32      32'h0000_0000
`endif

// ---- src/tcr_pkg.sv ----
package tcr_pkg;
    typedef enum logic {TCR_DN, TCR_UP} tcr_dir_e;
    typedef enum logic [1:0] {TCR_IDLE, TCR_ANS, TCR_DONE} tcr_bus_e;
    typedef logic [15:0] tcr_cnt_t;
endpackage : tcr_pkg

// ---- src/tcr_timer.sv ----
// Behaviour
// R1: Center mode counts up from zero to reload minus one, then overflow event.
// R2: After overflow count down to one, underflow event, then count up again from zero.
// R3: In center mode direction bit ignores writes and shows hardware direction.
// R4: Counter-driven updates and shadow loads happen only when repetition count hits zero.
// R5: update_generate makes an update and restarts counter and prescaler from zero.
// R6: update_disable blocks update events; counter keeps counting with current reload.
// R7: repetition_count is not buffered; new value acts on the running rate. Code: takes effect at next zero reload or update_generate.
// R8: With update_request_source set, update_generate does not set the update flag.
// R9: Update loads prescaler and reload shadows; flag per request source.
// R10: Entering center mode starts in the previously written direction.
// R11: Counter write above reload in center mode leaves direction unchanged.
// R12: Counter write of zero or reload sets direction but no update.
// R13: Software avoids direction plus mode in one write and running counter writes.
// R14: Repetition decrements on overflow up, underflow down, both in center mode.
// R15: Center mode repetition span is limited to 128 PWM cycles.
// R16: Software update acts at once and reloads the repetition down-counter.
// R17: Prescaler clock from system clock, edge input, trigger pin or internal trigger.
// R18: Slave off and mode 2 off: software controls, internal clock when running.
// R19: Slave mode 111 counts on chosen edge of selected timer input.
// R20: Trigger select 110 edges advance once, set trigger flag, interrupt if enabled.
// R21: ext_clock2_enable selects counting on filtered ext_trigger_input edges.
// R22: Polarity 0 picks rising edges; prescale 01 counts every second edge.
// R23: Counter advances only while gate, one cycle behind run bit, is active.
// R24: Non-zero center_mode_select means center mode; zero means edge-aligned.
`timescale 1ns/10ps
`default_nettype none
`include "tcr_consts.svh"
module tcr_timer (
    input  wire logic        I_CLK,
    input  wire logic        I_RESET,
    input  wire logic        I_CE,
    input  wire logic [7:0]  I_AVS_ADDRESS,
    input  wire logic        I_AVS_READ,
    input  wire logic        I_AVS_WRITE,
    input  wire logic [31:0] I_AVS_WRITEDATA,
    input  wire logic [3:0]  I_AVS_BYTEENABLE,
    output logic      [31:0] O_AVS_READDATA,
    output logic             O_AVS_WAITREQUEST,
    input  wire logic [1:0]  I_EDGE_IN,
    input  wire logic        I_ETR,
    input  wire logic [3:0]  I_ITRIG,
    output logic             O_UPDATE,
    output logic      [15:0] O_COUNT,
    output logic             O_DIR,
    output logic             O_TRIG_IRQ
);
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        merge = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                merge[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
    endfunction : merge

    tcr_pkg::tcr_bus_e bus_reg;
    logic [31:0]       ctrl_reg;
    logic [31:0]       slave_reg;
    tcr_pkg::tcr_cnt_t cnt_reg;
    tcr_pkg::tcr_cnt_t psc_pre_reg;
    tcr_pkg::tcr_cnt_t psc_sh_reg;
    tcr_pkg::tcr_cnt_t psc_cnt_reg;
    tcr_pkg::tcr_cnt_t arr_pre_reg;
    tcr_pkg::tcr_cnt_t arr_sh_reg;
    logic [7:0]        rep_reg;
    logic [7:0]        rep_cnt_reg;
    tcr_pkg::tcr_dir_e dir_reg;
    logic              gate_reg;
    logic              uif_reg;
    logic              tif_reg;
    logic [7:0]        src_prev_reg;
    logic [3:0]        flt_cnt_reg;
    logic              etr_flt_reg;
    logic [2:0]        ediv_reg;
    logic [7:0]        src;
    logic [7:0]        src_edge;
    logic              wr_go;
    logic [31:0]       wdata;
    logic              cnt_wr;
    logic              ug_go;
    logic              center;
    logic              ext2;
    logic              ext1;
    logic              psc_tick;
    logic              cnt_tick;
    logic              ovf;
    logic              udf;
    logic              rep_evt;
    logic              update_event;
    logic              ext2_edge;
    logic              etrp;
    logic [2:0]        ediv_top;

    // Bus handshake: request seen, one answer cycle, one recovery cycle
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            bus_reg           <= tcr_pkg::TCR_IDLE;
            O_AVS_WAITREQUEST <= 1'b1;
        end else if (I_CE) begin
            case (bus_reg)
                tcr_pkg::TCR_IDLE: begin
                    if (I_AVS_READ || I_AVS_WRITE) begin
                        bus_reg           <= tcr_pkg::TCR_ANS;
                        O_AVS_WAITREQUEST <= 1'b0;
                    end
                end
                tcr_pkg::TCR_ANS: begin
                    bus_reg           <= tcr_pkg::TCR_DONE;
                    O_AVS_WAITREQUEST <= 1'b1;
                end
                tcr_pkg::TCR_DONE: bus_reg <= tcr_pkg::TCR_IDLE;
                default:           bus_reg <= tcr_pkg::TCR_IDLE;
            endcase
        end
    end

    assign wr_go  = I_CE && I_AVS_WRITE && (bus_reg == tcr_pkg::TCR_ANS);
    assign wdata  = I_AVS_WRITEDATA;
    assign cnt_wr = wr_go && hit(I_AVS_ADDRESS, `TCR_OFF_COUNT);
    assign ug_go  = wr_go && hit(I_AVS_ADDRESS, `TCR_OFF_EVGEN) && wdata[`TCR_B_UG];

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            O_AVS_READDATA <= `TCR_ZERO32;
        end else if (I_CE && bus_reg == tcr_pkg::TCR_IDLE && I_AVS_READ) begin
            case (I_AVS_ADDRESS)
                `TCR_OFF_CTRL:   O_AVS_READDATA <= {ctrl_reg[31:2], dir_reg == tcr_pkg::TCR_DN, ctrl_reg[0]};
                `TCR_OFF_STATUS: O_AVS_READDATA <= {30'h0000_0000, tif_reg, uif_reg};
                `TCR_OFF_SLAVE:  O_AVS_READDATA <= slave_reg;
                `TCR_OFF_COUNT:  O_AVS_READDATA <= {16'h0000, cnt_reg};
                `TCR_OFF_PSC:    O_AVS_READDATA <= {16'h0000, psc_pre_reg};
                `TCR_OFF_ARR:    O_AVS_READDATA <= {16'h0000, arr_pre_reg};
                `TCR_OFF_REP:    O_AVS_READDATA <= {24'h00_0000, rep_reg};
                default:         O_AVS_READDATA <= `TCR_ZERO32;
            endcase
        end
    end

    // Software registers
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            ctrl_reg    <= `TCR_ZERO32;
            slave_reg   <= `TCR_ZERO32;
            psc_pre_reg <= `TCR_ZERO16;
            arr_pre_reg <= `TCR_ARR_RST;
            rep_reg     <= 8'h00;
        end else if (wr_go) begin
            case (I_AVS_ADDRESS)
                `TCR_OFF_CTRL:  ctrl_reg    <= merge(ctrl_reg, wdata, I_AVS_BYTEENABLE) & 32'h0000_007F;
                `TCR_OFF_SLAVE: slave_reg   <= merge(slave_reg, wdata, I_AVS_BYTEENABLE) & 32'h0003_FF77;
                `TCR_OFF_PSC:   psc_pre_reg <= 16'(merge({16'h0000, psc_pre_reg}, wdata, I_AVS_BYTEENABLE));
                `TCR_OFF_ARR:   arr_pre_reg <= 16'(merge({16'h0000, arr_pre_reg}, wdata, I_AVS_BYTEENABLE));
                `TCR_OFF_REP:   rep_reg     <= 8'(merge({24'h00_0000, rep_reg}, wdata, I_AVS_BYTEENABLE)); // see R7
                default:        rep_reg     <= rep_reg;
            endcase
        end
    end

    assign center = ctrl_reg[`TCR_F_CMS] != `TCR_CMS_EDGE; // see R24
    assign ext2   = slave_reg[`TCR_B_ECE]; // see R21
    assign ext1   = !ext2 && slave_reg[`TCR_F_SMS] == `TCR_SMS_EXT1; // see R19

    // External trigger filter: level must hold for the programmed samples
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            flt_cnt_reg <= 4'h0;
            etr_flt_reg <= 1'b0;
        end else if (I_CE) begin
            if (I_ETR == etr_flt_reg) begin
                flt_cnt_reg <= 4'h0;
            end else if (flt_cnt_reg >= slave_reg[`TCR_F_ETF]) begin
                etr_flt_reg <= I_ETR; // see R21
                flt_cnt_reg <= 4'h0;
            end else begin
                flt_cnt_reg <= flt_cnt_reg + 4'h1;
            end
        end
    end

    assign etrp = etr_flt_reg ^ slave_reg[`TCR_B_ETP]; // see R22
    assign src  = {etrp, I_EDGE_IN, 1'b0, I_ITRIG};

    // Edge detect on every trigger source
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_edge
            always_ff @(posedge I_CLK) begin
                if (I_RESET) begin
                    src_prev_reg[g] <= 1'b0;
                end else if (I_CE) begin
                    src_prev_reg[g] <= src[g];
                end
            end
            assign src_edge[g] = slave_reg[`TCR_B_EPOL] ? (src_prev_reg[g] && !src[g])
                                                          : (!src_prev_reg[g] && src[g]);
        end
    endgenerate

    assign ext2_edge = !src_prev_reg[7] && src[7];
    assign ediv_top  = 3'((4'h1 << slave_reg[`TCR_F_EXT_TRIGGER_PRESCALE]) - 4'h1);

    // Mode 2 edge prescaler: one tick per 1, 2, 4 or 8 edges
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            ediv_reg <= 3'h0;
        end else if (I_CE && ext2 && ext2_edge) begin
            ediv_reg <= (ediv_reg >= ediv_top) ? 3'h0 : ediv_reg + 3'h1; // see R22
        end
    end

    always_comb begin
        if (ext2) begin
            psc_tick = ext2_edge && ediv_reg >= ediv_top; // see R21
        end else if (ext1) begin
            psc_tick = src_edge[slave_reg[`TCR_F_TS]]; // see R19
        end else begin
            psc_tick = 1'b1; // see R17, R18
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            gate_reg <= 1'b0;
        end else if (I_CE) begin
            gate_reg <= ctrl_reg[`TCR_B_RUN]; // see R23
        end
    end

    // Prescaler counter
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            psc_cnt_reg <= `TCR_ZERO16;
        end else if (I_CE) begin
            if (ug_go) begin
                psc_cnt_reg <= `TCR_ZERO16; // see R5
            end else if (gate_reg && psc_tick) begin
                psc_cnt_reg <= (psc_cnt_reg >= psc_sh_reg) ? `TCR_ZERO16 : psc_cnt_reg + `TCR_ONE16;
            end
        end
    end

    assign cnt_tick = gate_reg && psc_tick && psc_cnt_reg >= psc_sh_reg; // see R23
    assign ovf = cnt_tick && dir_reg == tcr_pkg::TCR_UP &&
                 (center ? cnt_reg + `TCR_ONE16 >= arr_sh_reg : cnt_reg >= arr_sh_reg); // see R1
    assign udf = cnt_tick && dir_reg == tcr_pkg::TCR_DN &&
                 (center ? cnt_reg <= `TCR_ONE16 : cnt_reg == `TCR_ZERO16); // see R2
    assign rep_evt = !ug_go && (ovf || udf); // see R14
    assign update_event = !ctrl_reg[`TCR_B_UPDATE_DISABLE] && (ug_go || (rep_evt && rep_cnt_reg == 8'h00)); // see R4, R6

    // Repetition down-counter
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            rep_cnt_reg <= 8'h00;
        end else if (I_CE) begin
            if (ug_go) begin
                rep_cnt_reg <= rep_reg; // see R16
            end else if (rep_evt) begin
                rep_cnt_reg <= (rep_cnt_reg == 8'h00) ? rep_reg : rep_cnt_reg - 8'h01; // see R14, R15
            end
        end
    end

    // Shadows load on update; reload shadow also follows direct writes while ARPE is clear
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            arr_sh_reg <= `TCR_ARR_RST;
            psc_sh_reg <= `TCR_ZERO16;
        end else if (I_CE) begin
            if (update_event) begin
                arr_sh_reg <= arr_pre_reg; // see R9
                psc_sh_reg <= psc_pre_reg; // see R9
            end else if (!ctrl_reg[`TCR_B_ARPE]) begin
                arr_sh_reg <= arr_pre_reg;
            end
        end
    end

    // Main counter
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            cnt_reg <= `TCR_ZERO16;
        end else if (I_CE) begin
            if (ug_go) begin
                cnt_reg <= `TCR_ZERO16; // see R5
            end else if (cnt_wr) begin
                cnt_reg <= 16'(merge({16'h0000, cnt_reg}, wdata, I_AVS_BYTEENABLE)); // see R12
            end else if (cnt_tick) begin
                if (center) begin
                    cnt_reg <= (dir_reg == tcr_pkg::TCR_UP) ? cnt_reg + `TCR_ONE16 : cnt_reg - `TCR_ONE16;
                end else if (ovf) begin
                    cnt_reg <= `TCR_ZERO16;
                end else if (udf) begin
                    cnt_reg <= update_event ? arr_pre_reg : arr_sh_reg; // see R9
                end else begin
                    cnt_reg <= (dir_reg == tcr_pkg::TCR_UP) ? cnt_reg + `TCR_ONE16 : cnt_reg - `TCR_ONE16;
                end
            end
        end
    end

    // Direction: software in edge mode, hardware in center mode
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            dir_reg <= tcr_pkg::TCR_UP;
        end else if (I_CE) begin
            if (!center) begin
                if (wr_go && hit(I_AVS_ADDRESS, `TCR_OFF_CTRL) && I_AVS_BYTEENABLE[0]) begin
                    dir_reg <= wdata[`TCR_B_DIR] ? tcr_pkg::TCR_DN : tcr_pkg::TCR_UP; // see R10
                end
            end else if (cnt_wr) begin // see R11
                if (wdata[15:0] == `TCR_ZERO16) begin
                    dir_reg <= tcr_pkg::TCR_UP; // see R12
                end else if (wdata[15:0] == arr_sh_reg) begin
                    dir_reg <= tcr_pkg::TCR_DN; // see R12
                end
            end else if (!ug_go && ovf) begin
                dir_reg <= tcr_pkg::TCR_DN; // see R1, R3
            end else if (!ug_go && udf) begin
                dir_reg <= tcr_pkg::TCR_UP; // see R2, R3
            end
        end
    end

    // Sticky flags, set wins over write-one-to-clear
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            uif_reg <= 1'b0;
            tif_reg <= 1'b0;
        end else if (I_CE) begin
            if (update_event && !(ug_go && ctrl_reg[`TCR_B_URS])) begin
                uif_reg <= 1'b1; // see R8
            end else if (wr_go && hit(I_AVS_ADDRESS, `TCR_OFF_STATUS) && wdata[`TCR_B_UIF]) begin
                uif_reg <= 1'b0;
            end
            if (ext1 && gate_reg && psc_tick) begin
                tif_reg <= 1'b1; // see R20
            end else if (wr_go && hit(I_AVS_ADDRESS, `TCR_OFF_STATUS) && wdata[`TCR_B_TIF]) begin
                tif_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            O_UPDATE   <= 1'b0;
            O_COUNT    <= `TCR_ZERO16;
            O_DIR      <= 1'b0;
            O_TRIG_IRQ <= 1'b0;
        end else if (I_CE) begin
            O_UPDATE   <= update_event;
            O_COUNT    <= cnt_reg;
            O_DIR      <= dir_reg == tcr_pkg::TCR_DN;
            O_TRIG_IRQ <= tif_reg && slave_reg[`TCR_B_TIE]; // see R20
        end
    end

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RESET || !I_CE);

    AST_CENTER_OVF: assert property (center && ovf && !ug_go && !cnt_wr ##0 I_CE |=> // see R1
        dir_reg == tcr_pkg::TCR_DN && cnt_reg == $past(cnt_reg) + `TCR_ONE16)
        else $error("center overflow did not turn counter down");
    AST_CENTER_UDF: assert property (center && udf && !ug_go && !cnt_wr |=> // see R2
        dir_reg == tcr_pkg::TCR_UP && cnt_reg == `TCR_ZERO16)
        else $error("center underflow did not restart upward");
    AST_DIR_HOLD: assert property (center && !cnt_tick && !cnt_wr && !ug_go |=> // see R3
        dir_reg == $past(dir_reg))
        else $error("direction changed without hardware cause");
    AST_UG_RESTART: assert property (ug_go && !ctrl_reg[`TCR_B_UPDATE_DISABLE] |=> // see R5
        cnt_reg == `TCR_ZERO16 && psc_cnt_reg == `TCR_ZERO16 && O_UPDATE && rep_cnt_reg == rep_reg)
        else $error("update_generate did not restart");
    AST_UPDATE_DISABLE: assert property (ctrl_reg[`TCR_B_UPDATE_DISABLE] ##1 ctrl_reg[`TCR_B_UPDATE_DISABLE] |-> !O_UPDATE) // see R6
        else $error("update seen while disabled");
    AST_URS: assert property (ug_go && ctrl_reg[`TCR_B_URS] && !uif_reg |=> !uif_reg) // see R8
        else $error("software update set flag with request source set");
    AST_REP_COUNT: assert property (rep_evt && rep_cnt_reg != 8'h00 |=> // see R4
        !O_UPDATE && rep_cnt_reg == $past(rep_cnt_reg) - 8'h01)
        else $error("update before repetition reached zero");
    AST_GATE: assert property (!gate_reg && !ug_go && !cnt_wr |=> cnt_reg == $past(cnt_reg)) // see R23
        else $error("counter moved while gate closed");
    AST_WR_BIG: assert property (center && cnt_wr && wdata[15:0] > arr_sh_reg && !ug_go |=> // see R11
        dir_reg == $past(dir_reg))
        else $error("direction changed on oversize counter write");
    AST_SHADOW: assert property (update_event |=> psc_sh_reg == $past(psc_pre_reg)) // see R9
        else $error("prescaler shadow not loaded on update");

    COV_CENTER_OVF: cover property (center && ovf);
    COV_REP_UPD:    cover property (rep_evt && rep_cnt_reg == 8'h00 && rep_reg != 8'h00);
    COV_EXT2:       cover property (ext2 && cnt_tick);
    COV_UG_URS:     cover property (ug_go && ctrl_reg[`TCR_B_URS]);
endmodule : tcr_timer
`default_nettype wire

// ---- bench/tcr_pins_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module tcr_pins_model #(
    parameter int HOLD = 3
) (
    input  wire logic       i_clk,
    input  wire logic       i_go,
    input  wire logic [1:0] i_sel,
    input  wire logic [3:0] i_num,
    output logic            o_busy,
    output logic      [1:0] o_edge_in,
    output logic            o_etr,
    output logic      [3:0] o_itrig
);
    logic [3:0] left_reg = 4'h0;
    int         ph_reg   = 0;
    logic       lvl;
    // Pulse train: HOLD cycles high, HOLD low, per pulse
    always_ff @(posedge i_clk) begin
        if (i_go) begin
            left_reg <= i_num;
            ph_reg   <= 0;
        end else if (left_reg != 4'h0) begin
            ph_reg <= (ph_reg == 2 * HOLD - 1) ? 0 : ph_reg + 1;
            if (ph_reg == 2 * HOLD - 1) begin
                left_reg <= left_reg - 4'h1;
            end
        end
    end
    assign lvl       = (left_reg != 4'h0) && (ph_reg < HOLD);
    assign o_busy    = left_reg != 4'h0;
    assign o_edge_in = {i_sel == 2'h0 && lvl, 1'b0};
    assign o_etr     = i_sel == 2'h1 && lvl;
    assign o_itrig   = {3'h0, i_sel == 2'h2 && lvl};
endmodule : tcr_pins_model
`default_nettype wire

// ---- bench/tcr_timer_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "tcr_consts.svh"
module tcr_timer_tb;
    logic clk = 0, rst = 1, rd_en = 0, wr_en = 0, go = 0, busy, upd, dir, waitreq, irq, wait_q;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata, rdata_q, q;
    logic [1:0] sel = 2'h0, edge_in;
    logic [3:0] num = 4'h0, itrig;
    logic ext_trigger_input;
    logic [15:0] cnt;
    int errors = 0, checked = 0, upd_n = 0, n, g;
    always #10 clk = ~clk;
    always @(negedge clk) begin
        wait_q = waitreq;
        rdata_q = rdata;
        if (upd === 1'b1) upd_n++;
    end
    tcr_timer tcr_timer_inst (.I_CLK(clk), .I_RESET(rst), .I_CE(1'b1), .I_AVS_ADDRESS(addr),
        .I_AVS_READ(rd_en), .I_AVS_WRITE(wr_en), .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(4'hF),
        .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(waitreq), .I_EDGE_IN(edge_in), .I_ETR(ext_trigger_input),
        .I_ITRIG(itrig), .O_UPDATE(upd), .O_COUNT(cnt), .O_DIR(dir), .O_TRIG_IRQ(irq));
    tcr_pins_model #(.HOLD(3)) tcr_pins_model_inst (.i_clk(clk), .i_go(go), .i_sel(sel), .i_num(num),
        .o_busy(busy), .o_edge_in(edge_in), .o_etr(ext_trigger_input), .o_itrig(itrig));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= w;
        rd_en <= !w;
        do begin @(posedge clk); end while (wait_q !== 1'b0);
        q = rdata_q;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic reset_dut();
        @(posedge clk);
        rst <= 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask : reset_dut
    task automatic wait_upd();
        n = 0;
        do begin @(negedge clk); n++; end while (upd !== 1'b1 && n < 300);
    endtask : wait_upd
    task automatic gap();
        wait_upd();
        g = 0;
        do begin @(negedge clk); g++; end while (upd !== 1'b1 && g < 300);
    endtask : gap
    task automatic start_center(input logic [31:0] rep);
        reset_dut();
        bus(1, `TCR_OFF_ARR, 32'h0000_0004);
        bus(1, `TCR_OFF_REP, rep);
        bus(1, `TCR_OFF_CTRL, 32'h0000_0010);
        bus(1, `TCR_OFF_EVGEN, 32'h0000_0001);
    endtask : start_center
    task automatic t_reset();
        reset_dut();
        bus(0, `TCR_OFF_CTRL, 0); chk(q, 32'h0000_0000);
        bus(0, `TCR_OFF_ARR, 0); chk(q, 32'h0000_FFFF);
        bus(0, 8'h20, 0); chk(q, 32'h0000_0000);
        bus(1, `TCR_OFF_REP, 32'h0000_01FF);
        bus(0, `TCR_OFF_REP, 0); chk(q, 32'h0000_00FF);
    endtask : t_reset
    task automatic t_center();
        start_center(32'h0000_0000);
        bus(1, `TCR_OFF_CTRL, 32'h0000_0013);
        gap(); chk(g, 4);
        n = 0;
        repeat (16) begin @(negedge clk); if (dir === 1'b0) n++; end
        chk(n, 8);
    endtask : t_center
    task automatic t_repeat_and_disable();
        int m, mx;
        start_center(32'h0000_0003);
        bus(1, `TCR_OFF_CTRL, 32'h0000_0011);
        gap(); chk(g, 16);
        bus(1, `TCR_OFF_REP, 32'h0000_0001);
        wait_upd(); chk(upd, 1'b1);
        gap(); chk(g, 8);
        bus(1, `TCR_OFF_CTRL, 32'h0000_0015);
        m = upd_n;
        mx = 0;
        repeat (40) begin @(negedge clk); if (cnt > mx) mx = cnt; end
        chk(upd_n - m, 0);
        chk(mx, 4);
    endtask : t_repeat_and_disable
    task automatic t_soft_update();
        int m;
        reset_dut();
        bus(1, `TCR_OFF_CTRL, 32'h0000_0008);
        bus(1, `TCR_OFF_COUNT, 32'h0000_0005);
        m = upd_n;
        bus(1, `TCR_OFF_EVGEN, 32'h0000_0001);
        repeat (3) @(posedge clk);
        chk(upd_n - m, 1);
        bus(0, `TCR_OFF_STATUS, 0); chk(q[0], 1'b0);
        bus(0, `TCR_OFF_COUNT, 0); chk(q, 32'h0000_0000);
        bus(1, `TCR_OFF_CTRL, 32'h0000_0000);
        bus(1, `TCR_OFF_EVGEN, 32'h0000_0001);
        bus(0, `TCR_OFF_STATUS, 0); chk(q[0], 1'b1);
        bus(0, `TCR_OFF_EVGEN, 0); chk(q, 32'h0000_0000);
    endtask : t_soft_update
    task automatic t_count_write();
        int m;
        reset_dut();
        bus(1, `TCR_OFF_ARR, 32'h0000_0004);
        bus(1, `TCR_OFF_CTRL, 32'h0000_0010);
        m = upd_n;
        bus(1, `TCR_OFF_COUNT, 32'h0000_0004);
        bus(0, `TCR_OFF_CTRL, 0); chk(q[1], 1'b1);
        bus(1, `TCR_OFF_COUNT, 32'h0000_0009);
        bus(0, `TCR_OFF_CTRL, 0); chk(q[1], 1'b1);
        bus(1, `TCR_OFF_COUNT, 32'h0000_0000);
        bus(0, `TCR_OFF_CTRL, 0); chk(q[1], 1'b0);
        chk(upd_n - m, 0);
        reset_dut();
        bus(1, `TCR_OFF_ARR, 32'h0000_000A);
        bus(1, `TCR_OFF_CTRL, 32'h0000_0002);
        bus(1, `TCR_OFF_COUNT, 32'h0000_0005);
        bus(1, `TCR_OFF_CTRL, 32'h0000_0012);
        bus(1, `TCR_OFF_CTRL, 32'h0000_0013);
        n = 0;
        while (cnt === 16'h0005 && n < 50) begin @(negedge clk); n++; end
        chk(cnt, 16'h0004);
    endtask : t_count_write
    task automatic t_ext_clock();
        logic [31:0] cfg[5] = '{32'h0002_0067, 32'h0000_0500, 32'h0000_0007, 32'h0001_0067, 32'h0000_1300};
        logic [3:0] pulses[5] = '{4'h3, 4'h6, 4'h2, 4'h3, 4'h3};
        logic [31:0] exp[5] = '{32'h0000_0003, 32'h0000_0003, 32'h0000_0002, 32'h0000_0003, 32'h0000_0003};
        logic [1:0] sels[5] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h1};
        for (int i = 0; i < 5; i++) begin
            reset_dut();
            bus(1, `TCR_OFF_SLAVE, cfg[i]);
            bus(1, `TCR_OFF_CTRL, 32'h0000_0001);
            sel <= sels[i];
            num <= pulses[i];
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
            n = 0;
            do begin @(posedge clk); n++; end while (busy !== 1'b0 && n < 200);
            repeat (10) @(posedge clk);
            bus(0, `TCR_OFF_COUNT, 0); chk(q, exp[i]);
            if (i == 0) begin
                bus(0, `TCR_OFF_STATUS, 0); chk(q[1], 1'b1);
                chk(irq, 1'b1);
                bus(1, `TCR_OFF_STATUS, 32'h0000_0002);
                repeat (2) @(posedge clk);
                chk(irq, 1'b0);
            end
        end
    endtask : t_ext_clock
    task automatic tally_and_finish();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        tally_and_finish();
    end
    initial begin
        @(posedge clk);
        t_reset();
        t_center();
        t_repeat_and_disable();
        t_soft_update();
        t_count_write();
        t_ext_clock();
        tally_and_finish();
    end
endmodule : tcr_timer_tb
`default_nettype wire
